// [test/dltc_pin_model.sv]
// Model of the external count and gate pins.
`timescale 1ns/1ps
`default_nettype none
module dltc_pin_model
(
	// Clock and reset.
	input wire logic                 clk,
	input wire logic                 nrst,
	// Requests from the bench.
	input wire logic [1:0]           fire,
	input wire logic [1:0]           gateLvl,
	// Pins towards the timer.
	output var dltc_pkg::dltc_pins_t pins
);
	// Count pins idle high as with a pull-up; each pulse holds the count pin low two cycles.
	logic [2:0] cnt0;
	logic [2:0] cnt1;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt0 <= 3'h0;
			cnt1 <= 3'h0;
		end
		else
		begin
			cnt0 <= fire[0] ? 3'h4 : cnt0 - {2'h0, cnt0 != 3'h0};
			cnt1 <= fire[1] ? 3'h4 : cnt1 - {2'h0, cnt1 != 3'h0};
		end
	end
	assign pins = '{cnt0 < 3'h3, cnt1 < 3'h3, gateLvl[0], gateLvl[1]};
endmodule
`default_nettype wire

// [test/dltc_timer_props.sv]
// Concurrent checks on the dual timer ports.
`timescale 1ns/1ps
`default_nettype none
module dltc_timer_props
(
	// Clock and reset.
	input wire logic        clk,
	input wire logic        nrst,
	// Bus.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Flags.
	input wire logic        t0IntEnter,
	input wire logic        t1IntEnter,
	input wire logic        t0OverflowFlag,
	input wire logic        t1OverflowFlag
);
	logic ok;
	logic wrRun;
	assign ok = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 &&
		(paddr[9:2] inside {[8'h88:8'h8E], 8'h90});
	assign wrRun = psel && penable && pwrite && pstrb[0] && paddr == 12'h220;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_rd;
		s_acc ##0 !pwrite;
	endsequence
	a_ready_high: assert property (s_acc |-> pready)
		else $error("pready low in access");
	a_bad_addr_err: assert property (s_acc ##0 !ok |-> pslverr)
		else $error("no error on unmapped access");
	a_good_addr_ok: assert property (s_acc ##0 ok |-> !pslverr)
		else $error("error on mapped access");
	a_read_upper_zero: assert property (s_rd |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_bad_read_zero: assert property (s_rd ##0 !ok |-> prdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_t0_flag_clear: assert property ($fell(t0OverflowFlag) |-> $past(t0IntEnter) || $past(wrRun))
		else $error("timer zero flag fell without cause");
	a_t1_flag_clear: assert property ($fell(t1OverflowFlag) |-> $past(t1IntEnter) || $past(wrRun))
		else $error("timer one flag fell without cause");
	a_sw_flag_set: assert property (wrRun && pwdata[5] |=> t0OverflowFlag)
		else $error("written flag not set");
endmodule
bind dltc_timer dltc_timer_props dltc_timer_props_i
(
	.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
	.pslverr, .t0IntEnter, .t1IntEnter, .t0OverflowFlag, .t1OverflowFlag
);
`default_nettype wire

// [test/dltc_timer_tb.sv]
// Self-checking bench for the dual timer block.
`timescale 1ns/1ps
`default_nettype none
module dltc_timer_tb;
	logic        clk;
	logic        nrst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [1:0]  intEnter;
	logic [1:0]  fire;
	logic [1:0]  gateLvl;
	logic [1:0]  flag;
	logic [7:0]  rd;
	int          nFail = 0;
	int          nChecks = 0;
	int          cyc = 0;
	int          c;
	dltc_pkg::dltc_pins_t pins;
	dltc_timer dltc_timer_i
	(
		.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
		.pslverr, .pins, .t0IntEnter(intEnter[0]), .t1IntEnter(intEnter[1]),
		.t0OverflowFlag(flag[0]), .t1OverflowFlag(flag[1])
	);
	dltc_pin_model dltc_pin_model_i
	(
		.clk, .nrst, .fire, .gateLvl, .pins
	);
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			nFail++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", nChecks, nFail);
		if (nFail == 0 && nChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] lo, hi, got);
		nChecks++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			nFail++;
			$display("wrong value %s expected %0h..%0h seen %0h", nm, lo, hi, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
		begin
			@(posedge clk);
		end
		rd = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic waitFlag(input int k);
		c = 0;
		while (flag[k] !== 1'b1 && c < 5000)
		begin
			@(posedge clk);
			c++;
		end
	endtask
	task automatic pulse(input int n);
		repeat (n)
		begin
			fire <= 2'b11;
			@(posedge clk);
			fire <= 2'b00;
			repeat (6) @(posedge clk);
		end
	endtask
	task automatic t_regs();
		logic [7:0] exp [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC7};
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b0, 12'h220 + 12'(4 * i), 8'h00);
			chk("reset value", {8'h00, exp[i]}, {8'h00, exp[i]}, {8'h00, rd});
		end
		apb(1'b0, 12'h23C, 8'h00);
		chk("unmapped read", 16'h0000, 16'h0000, {8'h00, rd});
		apb(1'b1, 12'h224, 8'hA5);
		apb(1'b0, 12'h224, 8'h00);
		chk("mode readback", 16'h00A5, 16'h00A5, {8'h00, rd});
		pstrb <= 4'hE;
		apb(1'b1, 12'h224, 8'h5A);
		pstrb <= 4'hF;
		apb(1'b0, 12'h224, 8'h00);
		chk("strobe-less write", 16'h00A5, 16'h00A5, {8'h00, rd});
		apb(1'b1, 12'h220, 8'hA0);
		chk("software flag set", 16'h0003, 16'h0003, {14'h0000, flag});
		apb(1'b1, 12'h220, 8'h00);
		chk("software flag clear", 16'h0000, 16'h0000, {14'h0000, flag});
		$display("register test done");
	endtask
	task automatic t_reload(input int k, input int f);
		int div;
		div = f ? 4 : 12;
		apb(1'b1, 12'h238, 8'hC7 | 8'(f << (3 + k)));
		apb(1'b1, 12'h224, 8'(2 << (4 * k)));
		apb(1'b1, 12'h230 + 12'(4 * k), 8'hFE);
		apb(1'b1, 12'h228 + 12'(4 * k), 8'hFE);
		apb(1'b1, 12'h220, 8'(1 << (4 + 2 * k)));
		waitFlag(k);
		intEnter <= 2'(1 << k);
		@(posedge clk);
		intEnter <= 2'b00;
		@(posedge clk);
		chk("flag after entry", 16'h0000, 16'h0000, {15'h0000, flag[k]});
		waitFlag(k);
		chk("reload period", 16'(2 * div - 2), 16'(2 * div - 2), 16'(c));
		apb(1'b1, 12'h220, 8'h00);
		apb(1'b0, 12'h230 + 12'(4 * k), 8'h00);
		chk("reload source", 16'h00FE, 16'h00FE, {8'h00, rd});
		$display("reload test done");
	endtask
	task automatic t_span(input int k, input int m, input int ticks);
		apb(1'b1, 12'h238, 8'hDF);
		apb(1'b1, 12'h224, 8'(m << (4 * k)));
		apb(1'b1, 12'h230 + 12'(4 * k), 8'hFF);
		apb(1'b1, 12'h228 + 12'(4 * k), 8'h00);
		apb(1'b1, 12'h220, 8'(1 << (4 + 2 * k)));
		waitFlag(k);
		chk("overflow span", 16'(4 * ticks - 8), 16'(4 * ticks + 8), 16'(c));
		apb(1'b1, 12'h220, 8'h00);
		$display("span test done");
	endtask
	task automatic t_count();
		apb(1'b1, 12'h224, 8'h55);
		apb(1'b1, 12'h228, 8'h00);
		apb(1'b1, 12'h22C, 8'h00);
		apb(1'b1, 12'h230, 8'h00);
		apb(1'b1, 12'h234, 8'h00);
		apb(1'b1, 12'h220, 8'h50);
		pulse(5);
		apb(1'b1, 12'h224, 8'hDD);
		gateLvl <= 2'b00;
		pulse(3);
		gateLvl <= 2'b11;
		pulse(2);
		apb(1'b1, 12'h220, 8'h00);
		pulse(2);
		apb(1'b0, 12'h228, 8'h00);
		chk("pin count zero", 16'h0007, 16'h0007, {8'h00, rd});
		apb(1'b0, 12'h22C, 8'h00);
		chk("pin count one", 16'h0007, 16'h0007, {8'h00, rd});
		$display("count test done");
	endtask
	task automatic t_split();
		apb(1'b1, 12'h224, 8'h33);
		apb(1'b1, 12'h230, 8'hFF);
		apb(1'b1, 12'h228, 8'hFF);
		apb(1'b1, 12'h22C, 8'h55);
		apb(1'b1, 12'h220, 8'h40);
		waitFlag(1);
		chk("split high byte", 16'h0000, 16'h0028, 16'(c));
		chk("split low flag", 16'h0000, 16'h0000, {15'h0000, flag[0]});
		apb(1'b1, 12'h220, 8'h10);
		waitFlag(0);
		chk("split low byte", 16'h0000, 16'h0028, 16'(c));
		chk("split high flag", 16'h0000, 16'h0000, {15'h0000, flag[1]});
		apb(1'b1, 12'h220, 8'h00);
		apb(1'b0, 12'h22C, 8'h00);
		chk("timer one hold", 16'h0055, 16'h0055, {8'h00, rd});
		$display("split test done");
	endtask
	initial
	begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
		intEnter = 2'b00;
		fire = 2'b00;
		gateLvl = 2'b11;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_regs();
		for (int i = 0; i < 4; i++)
			t_reload(i / 2, i % 2);
		for (int i = 0; i < 4; i++)
			t_span(i / 2, i % 2, (i % 2) ? 256 : 32);
		t_count();
		t_split();
		summarize();
	end
endmodule
`default_nettype wire

// [verilog/dltc_pkg.sv]
// Package with register map, field positions and timing constants of the dual timer block.
`default_nettype none
package dltc_pkg;
	localparam logic [7:0] REG_RUN_FLAG = 8'h88;
	localparam logic [7:0] REG_MODE     = 8'h89;
	localparam logic [7:0] REG_T0_LOW   = 8'h8A;
	localparam logic [7:0] REG_T1_LOW   = 8'h8B;
	localparam logic [7:0] REG_T0_HIGH  = 8'h8C;
	localparam logic [7:0] REG_T1_HIGH  = 8'h8D;
	localparam logic [7:0] REG_CLK_DIV  = 8'h8E;
	localparam logic [7:0] REG_INT_ACK  = 8'h90;

	localparam int RUN_T1_FLAG = 7;
	localparam int RUN_T1_RUN  = 6;
	localparam int RUN_T0_FLAG = 5;
	localparam int RUN_T0_RUN  = 4;
	localparam int MODE_T1_LSB = 4;
	localparam int MODE_T0_LSB = 0;
	localparam int FLD_GATE    = 3;
	localparam int FLD_CSEL    = 2;
	localparam int DIV_T1_SEL  = 4;
	localparam int DIV_T0_SEL  = 3;

	localparam logic [7:0] RUN_FLAG_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET     = 8'h00;
	localparam logic [7:0] COUNT_RESET    = 8'h00;
	localparam logic [7:0] CLK_DIV_RESET  = 8'hC7;
	localparam logic [7:0] CLK_DIV_MASK   = 8'hFC;

	localparam logic [1:0] MODE_13BIT  = 2'h0;
	localparam logic [1:0] MODE_16BIT  = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT  = 2'h3;

	localparam logic [3:0] DIV_SLOW = 4'hB;
	localparam logic [3:0] DIV_FAST = 4'h3;
	localparam logic [4:0] PRESCALE_MAX = 5'h1F;

	typedef enum logic [2:0]
	{
		APB_IDLE   = 3'b001,
		APB_SETUP  = 3'b010,
		APB_ACCESS = 3'b100
	} dltc_apb_t;

	typedef struct packed
	{
		logic [7:0] runFlag;
		logic [7:0] mode;
		logic [7:0] t0Low;
		logic [7:0] t0High;
		logic [7:0] t1Low;
		logic [7:0] t1High;
		logic [7:0] clkDiv;
		logic [3:0] pre0;
		logic [3:0] pre1;
		logic [1:0] pinSample;
		logic [1:0] pinPrev;
		logic [31:0] rdata;
		dltc_apb_t  apbState;
	} dltc_state_t;

	typedef struct packed
	{
		logic countPinZero;
		logic countPinOne;
		logic gatePinZero;
		logic gatePinOne;
	} dltc_pins_t;
endpackage
`default_nettype wire

// [verilog/dltc_timer.sv]
// Dual legacy 16-bit timer/counter with APB register access.
`timescale 1ns/1ps
`default_nettype none
module dltc_timer
(
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              nrst,
	// APB slave.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// External pins.
	input  wire dltc_pkg::dltc_pins_t pins,
	// Interrupt entry acknowledge and overflow flags towards the processor.
	input  wire logic              t0IntEnter,
	input  wire logic              t1IntEnter,
	output logic                   t0OverflowFlag,
	output logic                   t1OverflowFlag
);
	dltc_pkg::dltc_state_t st_reg;
	dltc_pkg::dltc_state_t st_next;

	logic       wrEn;
	logic       rdEn;
	logic       mapped;
	logic [7:0] regIdx;
	logic [7:0] wbyte;
	logic [1:0] fall;
	logic [1:0] modeT0;
	logic [1:0] modeT1;
	logic       tick0;
	logic       tick1;
	logic       tickSplit;
	logic       en0;
	logic       en1;
	logic       enSplit;
	logic       ovf0;
	logic       ovf1;
	logic [7:0] cnt8;
	logic [4:0] pre5;
	logic [7:0] rv;

	always_comb
	begin
		regIdx = paddr[9:2];
		wbyte  = pwdata[7:0];
		mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
			((regIdx >= dltc_pkg::REG_RUN_FLAG && regIdx <= dltc_pkg::REG_CLK_DIV) ||
			regIdx == dltc_pkg::REG_INT_ACK);
		// Writes act only in an access phase that followed its own setup.
		wrEn   = psel && penable && pwrite && mapped && pstrb[0] &&
			(st_reg.apbState == dltc_pkg::APB_SETUP);
		rdEn   = psel && !penable && !pwrite;
		modeT0 = st_reg.mode[dltc_pkg::MODE_T0_LSB +: 2];
		modeT1 = st_reg.mode[dltc_pkg::MODE_T1_LSB +: 2];
		fall   = st_reg.pinPrev & ~st_reg.pinSample;
		// Internal ticks fire on the last state of each divider.
		tick0 = st_reg.mode[dltc_pkg::MODE_T0_LSB + dltc_pkg::FLD_CSEL] ? fall[0] :
			(st_reg.pre0 == 4'h0);
		tick1 = st_reg.mode[dltc_pkg::MODE_T1_LSB + dltc_pkg::FLD_CSEL] ? fall[1] :
			(st_reg.pre1 == 4'h0);
		// Split high byte is always a timer on the zero divider.
		tickSplit = (st_reg.pre0 == 4'h0);
		en0 = st_reg.runFlag[dltc_pkg::RUN_T0_RUN] &&
			(!st_reg.mode[dltc_pkg::MODE_T0_LSB + dltc_pkg::FLD_GATE] || pins.gatePinZero);
		en1 = st_reg.runFlag[dltc_pkg::RUN_T1_RUN] &&
			(!st_reg.mode[dltc_pkg::MODE_T1_LSB + dltc_pkg::FLD_GATE] || pins.gatePinOne);
		enSplit = st_reg.runFlag[dltc_pkg::RUN_T1_RUN];
	end

	always_comb
	begin
		st_next = st_reg;
		ovf0 = 1'b0;
		ovf1 = 1'b0;
		cnt8 = 8'h00;
		pre5 = 5'h00;
		rv   = 8'h00;
		st_next.pinSample = {pins.countPinOne, pins.countPinZero};
		st_next.pinPrev   = st_reg.pinSample;
		// Dividers free-run; reload picks twelve or four.
		st_next.pre0 = (st_reg.pre0 == 4'h0) ?
			(st_reg.clkDiv[dltc_pkg::DIV_T0_SEL] ? dltc_pkg::DIV_FAST : dltc_pkg::DIV_SLOW) :
			st_reg.pre0 - 4'h1;
		st_next.pre1 = (st_reg.pre1 == 4'h0) ?
			(st_reg.clkDiv[dltc_pkg::DIV_T1_SEL] ? dltc_pkg::DIV_FAST : dltc_pkg::DIV_SLOW) :
			st_reg.pre1 - 4'h1;

		// Timer zero.
		if (en0 && tick0)
		begin
			case (modeT0)
				dltc_pkg::MODE_13BIT:
				begin
					pre5 = st_reg.t0Low[4:0] + 5'h01;
					st_next.t0Low = {st_reg.t0Low[7:5], pre5};
					if (st_reg.t0Low[4:0] == dltc_pkg::PRESCALE_MAX)
					begin
						st_next.t0High = st_reg.t0High + 8'h01;
						ovf0 = (st_reg.t0High == 8'hFF);
					end
				end
				dltc_pkg::MODE_16BIT:
				begin
					st_next.t0Low = st_reg.t0Low + 8'h01;
					if (st_reg.t0Low == 8'hFF)
					begin
						st_next.t0High = st_reg.t0High + 8'h01;
						ovf0 = (st_reg.t0High == 8'hFF);
					end
				end
				dltc_pkg::MODE_RELOAD:
				begin
					st_next.t0Low = (st_reg.t0Low == 8'hFF) ? st_reg.t0High :
						st_reg.t0Low + 8'h01;
					ovf0 = (st_reg.t0Low == 8'hFF);
				end
				dltc_pkg::MODE_SPLIT:
				begin
					st_next.t0Low = st_reg.t0Low + 8'h01;
					ovf0 = (st_reg.t0Low == 8'hFF);
				end
				default:
				begin
					ovf0 = 1'b0;
				end
			endcase
		end
		if (modeT0 == dltc_pkg::MODE_SPLIT && enSplit && tickSplit)
		begin
			st_next.t0High = st_reg.t0High + 8'h01;
			ovf1 = (st_reg.t0High == 8'hFF);
		end

		// Timer one; its flag belongs to the split byte while timer zero is split.
		if (en1 && tick1)
		begin
			case (modeT1)
				dltc_pkg::MODE_13BIT:
				begin
					pre5 = st_reg.t1Low[4:0] + 5'h01;
					st_next.t1Low = {st_reg.t1Low[7:5], pre5};
					if (st_reg.t1Low[4:0] == dltc_pkg::PRESCALE_MAX)
					begin
						st_next.t1High = st_reg.t1High + 8'h01;
						ovf1 = ovf1 || (modeT0 != dltc_pkg::MODE_SPLIT &&
							st_reg.t1High == 8'hFF);
					end
				end
				dltc_pkg::MODE_16BIT:
				begin
					st_next.t1Low = st_reg.t1Low + 8'h01;
					if (st_reg.t1Low == 8'hFF)
					begin
						st_next.t1High = st_reg.t1High + 8'h01;
						ovf1 = ovf1 || (modeT0 != dltc_pkg::MODE_SPLIT &&
							st_reg.t1High == 8'hFF);
					end
				end
				dltc_pkg::MODE_RELOAD:
				begin
					cnt8 = (st_reg.t1Low == 8'hFF) ? st_reg.t1High : st_reg.t1Low + 8'h01;
					st_next.t1Low = cnt8;
					ovf1 = ovf1 || (modeT0 != dltc_pkg::MODE_SPLIT &&
						st_reg.t1Low == 8'hFF);
				end
				dltc_pkg::MODE_SPLIT:
				begin
					// Timer one has no split form and simply holds.
					st_next.t1Low = st_reg.t1Low;
				end
				default:
				begin
					st_next.t1Low = st_reg.t1Low;
				end
			endcase
		end

		// Software writes, then hardware clears, then hardware sets; a set always wins.
		if (wrEn)
		begin
			case (regIdx)
				dltc_pkg::REG_RUN_FLAG: st_next.runFlag = wbyte;
				dltc_pkg::REG_MODE:     st_next.mode = wbyte;
				dltc_pkg::REG_T0_LOW:   st_next.t0Low = wbyte;
				dltc_pkg::REG_T1_LOW:   st_next.t1Low = wbyte;
				dltc_pkg::REG_T0_HIGH:  st_next.t0High = wbyte;
				dltc_pkg::REG_T1_HIGH:  st_next.t1High = wbyte;
				dltc_pkg::REG_CLK_DIV:  st_next.clkDiv = wbyte & dltc_pkg::CLK_DIV_MASK;
				default:                st_next.mode = st_next.mode;
			endcase
		end
		if (t0IntEnter)
		begin
			st_next.runFlag[dltc_pkg::RUN_T0_FLAG] = 1'b0;
		end
		if (t1IntEnter)
		begin
			st_next.runFlag[dltc_pkg::RUN_T1_FLAG] = 1'b0;
		end
		if (ovf0)
		begin
			st_next.runFlag[dltc_pkg::RUN_T0_FLAG] = 1'b1;
		end
		if (ovf1)
		begin
			st_next.runFlag[dltc_pkg::RUN_T1_FLAG] = 1'b1;
		end

		// APB read data is captured in setup so the access phase has one wait-free answer.
		case (regIdx)
			dltc_pkg::REG_RUN_FLAG: rv = st_reg.runFlag;
			dltc_pkg::REG_MODE:     rv = st_reg.mode;
			dltc_pkg::REG_T0_LOW:   rv = st_reg.t0Low;
			dltc_pkg::REG_T1_LOW:   rv = st_reg.t1Low;
			dltc_pkg::REG_T0_HIGH:  rv = st_reg.t0High;
			dltc_pkg::REG_T1_HIGH:  rv = st_reg.t1High;
			dltc_pkg::REG_CLK_DIV:  rv = st_reg.clkDiv;
			default:                rv = 8'h00;
		endcase
		if (rdEn)
		begin
			st_next.rdata = {24'h000000, mapped ? rv : 8'h00};
		end

		case (st_reg.apbState)
			dltc_pkg::APB_IDLE:
				st_next.apbState = (psel && !penable) ? dltc_pkg::APB_SETUP : dltc_pkg::APB_IDLE;
			dltc_pkg::APB_SETUP:
				st_next.apbState = dltc_pkg::APB_ACCESS;
			dltc_pkg::APB_ACCESS:
				st_next.apbState = (psel && !penable) ? dltc_pkg::APB_SETUP : dltc_pkg::APB_IDLE;
			default:
				st_next.apbState = dltc_pkg::APB_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_reg.runFlag   <= dltc_pkg::RUN_FLAG_RESET;
			st_reg.mode      <= dltc_pkg::MODE_RESET;
			st_reg.t0Low     <= dltc_pkg::COUNT_RESET;
			st_reg.t0High    <= dltc_pkg::COUNT_RESET;
			st_reg.t1Low     <= dltc_pkg::COUNT_RESET;
			st_reg.t1High    <= dltc_pkg::COUNT_RESET;
			st_reg.clkDiv    <= dltc_pkg::CLK_DIV_RESET;
			st_reg.pre0      <= dltc_pkg::DIV_SLOW;
			st_reg.pre1      <= dltc_pkg::DIV_SLOW;
			st_reg.pinSample <= 2'h3;
			st_reg.pinPrev   <= 2'h3;
			st_reg.rdata     <= 32'h00000000;
			st_reg.apbState  <= dltc_pkg::APB_IDLE;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign pready         = 1'b1;
	assign pslverr        = psel && penable && !mapped;
	assign prdata         = st_reg.rdata;
	assign t0OverflowFlag = st_reg.runFlag[dltc_pkg::RUN_T0_FLAG];
	assign t1OverflowFlag = st_reg.runFlag[dltc_pkg::RUN_T1_FLAG];
endmodule
`default_nettype wire
